// ===== core/lco_defs.vh
/*
  lco_defs.vh: command codes, field positions, reset values for the
  cursor / overlay / memory access command interpreter.
  assumes: included by bare name from core modules.
*/
`ifndef LCO_DEFS_VH
`define LCO_DEFS_VH
// command codes
`define LCO_CMD_CSR_FORM     8'h5D
`define LCO_CMD_DIR_BASE     6'h13
`define LCO_CMD_OVERLAY      8'h5B
`define LCO_CMD_CHARGEN      8'h5C
`define LCO_CMD_HSCROLL      8'h5A
`define LCO_CMD_CSR_WRITE    8'h46
`define LCO_CMD_CSR_READ     8'h47
`define LCO_CMD_MEM_WRITE    8'h42
`define LCO_CMD_MEM_READ     8'h43
// direction codes
`define LCO_DIR_RIGHT        2'h0
`define LCO_DIR_LEFT         2'h1
`define LCO_DIR_UP           2'h2
`define LCO_DIR_DOWN         2'h3
// reset values
`define LCO_RST_PITCH        16'h0028
`define LCO_RST_CRX          4'h7
`define LCO_RST_CRY          4'h7
// field positions
`define LCO_FORM_CM_BIT      7
`define LCO_OV_MX_LO         0
`define LCO_OV_DM1_BIT       2
`define LCO_OV_DM2_BIT       3
`define LCO_OV_OV_BIT        4
// cursor lookahead on reads while cursor shown
`define LCO_READ_AHEAD       16'h0002
`endif

// ===== core/lco_buf2.v
/*
  lco_buf2.v: two-entry skid buffer with valid/ready on both sides.
  assumes: one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module lco_buf2
#(
  parameter W = 24
)
(
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg  [W-1:0] mem_r [0:1];
  reg          wp_r;
  reg          rp_r;
  reg  [1:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule // lco_buf2

// ===== core/lco_cmd.v
/*
  lco_cmd.v: command interpreter for cursor form, cursor direction,
  overlay, pixel scroll, cursor address write/read and streaming
  memory write/read.
  assumes: host bytes already decoded into one-cycle strobes on CLK_SYS;
  display memory port answers a read with MEM_RD_VALID some cycles later.
*/
`timescale 1ns/100ps
`include "lco_defs.vh"
module lco_cmd
#(
  parameter AW = 16
)
(
  // clock and reset
  input  wire          CLK_SYS,
  input  wire          RST_N,
  // host byte strobes
  input  wire          CMD_WR,
  input  wire          DAT_WR,
  input  wire [7:0]    HOST_DIN,
  input  wire          DAT_RD,
  output reg  [7:0]    HOST_DOUT,
  output reg           HOST_DOUT_VALID,
  // configuration inputs
  input  wire [15:0]   ADDR_PITCH,
  input  wire          CURSOR_SHOWN,
  // display memory port
  output reg           MEM_REQ,
  output reg           MEM_WE,
  output reg  [AW-1:0] MEM_ADDR,
  output reg  [7:0]    MEM_WDATA,
  input  wire          MEM_READY,
  input  wire          MEM_RD_VALID,
  input  wire [7:0]    MEM_RDATA,
  // cursor and overlay state
  output reg  [AW-1:0] CURSOR_ADDR,
  output reg  [3:0]    CURSOR_HORZ,
  output reg  [3:0]    CURSOR_VERT_FIELD,
  output reg           CURSOR_SHAPE_BIT,
  output reg           CURSOR_VERT_ILLEGAL,
  output reg  [3:0]    UNDERLINE_ROW,
  output reg  [4:0]    BLOCK_HEIGHT,
  output reg           DIR_SELECT_HI,
  output reg           DIR_SELECT_LO,
  output reg  [1:0]    COMPOSITION_SELECT,
  output reg           BLOCK1_MODE_BIT,
  output reg           BLOCK3_MODE_BIT,
  output reg           LAYER_COUNT_BIT,
  output reg           LAYER3_ENABLE,
  output reg           BLOCK1_GRAPHICS,
  output reg           BLOCK3_GRAPHICS,
  output reg  [2:0]    PIXEL_HSCROLL,
  output reg  [15:0]   CHARGEN_BASE
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_FORM  = 3'h1;
  localparam ST_OVL   = 3'h2;
  localparam ST_HSCR  = 3'h3;
  localparam ST_CURSOR_ADDR_WRITE_CMD  = 3'h4;
  localparam ST_CURSOR_ADDR_READ_CMD  = 3'h5;
  localparam ST_MWR   = 3'h6;
  localparam ST_MRD   = 3'h7;

  reg  [2:0]    st_r;
  reg           pidx_r;
  reg           hi_next_r;
  reg  [AW-1:0] step_r;
  reg           wait_rd_r;
  wire [1:0]    dir_w;
  wire [7:0]    cmd_w;
  wire          bq_ready;
  wire          bq_valid;
  wire [AW+7:0] bq_data;
  reg           bq_push;
  wire          bq_pop;
  wire          prefetch;

  assign dir_w = {DIR_SELECT_HI, DIR_SELECT_LO};
  assign cmd_w = HOST_DIN;

  always @*
  begin
    case (dir_w)
      `LCO_DIR_RIGHT: step_r = {{(AW-1){1'b0}}, 1'b1};
      `LCO_DIR_LEFT:  step_r = {AW{1'b1}};
      `LCO_DIR_UP:    step_r = ~ADDR_PITCH[AW-1:0] + {{(AW-1){1'b0}}, 1'b1};
      `LCO_DIR_DOWN:  step_r = ADDR_PITCH[AW-1:0];
      default:        step_r = {{(AW-1){1'b0}}, 1'b1};
    endcase
  end

  // cursor address queued with byte; a byte sent while the buffer is full is lost
  always @*
  begin
    bq_push = DAT_WR && !CMD_WR && (st_r == ST_MWR);
  end

  lco_buf2 #(.W(AW + 8)) i_lco_buf2
  (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .in_valid  (bq_push),
    .in_ready  (bq_ready),
    .in_data   ({CURSOR_ADDR, HOST_DIN}),
    .out_valid (bq_valid),
    .out_ready (bq_pop),
    .out_data  (bq_data)
  );

  assign bq_pop   = bq_valid && (!MEM_REQ || MEM_READY) && !wait_rd_r;
  assign prefetch = (st_r == ST_MRD) && !wait_rd_r && !HOST_DOUT_VALID && !MEM_REQ;

  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      st_r                <= ST_IDLE;
      pidx_r              <= 1'b0;
      hi_next_r           <= 1'b0;
      wait_rd_r           <= 1'b0;
      HOST_DOUT           <= 8'h00;
      HOST_DOUT_VALID     <= 1'b0;
      MEM_REQ             <= 1'b0;
      MEM_WE              <= 1'b0;
      MEM_ADDR            <= {AW{1'b0}};
      MEM_WDATA           <= 8'h00;
      CURSOR_ADDR         <= {AW{1'b0}};
      CURSOR_HORZ         <= `LCO_RST_CRX;
      CURSOR_VERT_FIELD   <= `LCO_RST_CRY;
      CURSOR_SHAPE_BIT    <= 1'b1;
      CURSOR_VERT_ILLEGAL <= 1'b0;
      UNDERLINE_ROW       <= `LCO_RST_CRY;
      BLOCK_HEIGHT        <= 5'h08;
      DIR_SELECT_HI       <= 1'b0;
      DIR_SELECT_LO       <= 1'b0;
      COMPOSITION_SELECT  <= 2'h0;
      BLOCK1_MODE_BIT     <= 1'b0;
      BLOCK3_MODE_BIT     <= 1'b0;
      LAYER_COUNT_BIT     <= 1'b0;
      LAYER3_ENABLE       <= 1'b0;
      BLOCK1_GRAPHICS     <= 1'b0;
      BLOCK3_GRAPHICS     <= 1'b0;
      PIXEL_HSCROLL       <= 3'h0;
      CHARGEN_BASE        <= 16'h0000;
    end
    else
    begin
      // memory port handshake
      if (MEM_REQ && MEM_READY)
        MEM_REQ <= 1'b0;
      if (bq_pop)
      begin
        MEM_REQ   <= 1'b1;
        MEM_WE    <= 1'b1;
        MEM_ADDR  <= bq_data[AW+7:8];
        MEM_WDATA <= bq_data[7:0];
      end
      // read two ahead with cursor shown
      else if (prefetch)
      begin
        MEM_REQ   <= 1'b1;
        MEM_WE    <= 1'b0;
        MEM_ADDR  <= CURSOR_SHOWN ? CURSOR_ADDR + `LCO_READ_AHEAD : CURSOR_ADDR;
        wait_rd_r <= 1'b1;
      end
      if (MEM_RD_VALID && wait_rd_r)
      begin
        wait_rd_r       <= 1'b0;
        HOST_DOUT       <= (st_r == ST_MRD) ? MEM_RDATA : HOST_DOUT;
        HOST_DOUT_VALID <= (st_r == ST_MRD);
      end

      if (CMD_WR)
      begin
        pidx_r          <= 1'b0;
        HOST_DOUT_VALID <= 1'b0;
        if (cmd_w[7:2] == `LCO_CMD_DIR_BASE)
        begin
          DIR_SELECT_HI <= cmd_w[1];
          DIR_SELECT_LO <= cmd_w[0];
          st_r          <= ST_IDLE;
        end
        else
        begin
          case (cmd_w)
            `LCO_CMD_CSR_FORM:  st_r <= ST_FORM;
            `LCO_CMD_OVERLAY:   st_r <= ST_OVL;
            `LCO_CMD_HSCROLL:   st_r <= ST_HSCR;
            `LCO_CMD_CHARGEN:   st_r <= ST_HSCR;
            `LCO_CMD_CSR_WRITE: st_r <= ST_CURSOR_ADDR_WRITE_CMD;
            `LCO_CMD_MEM_WRITE: st_r <= ST_MWR;
            `LCO_CMD_CSR_READ:
            begin
              st_r            <= ST_CURSOR_ADDR_READ_CMD;
              hi_next_r       <= 1'b0;
              HOST_DOUT       <= CURSOR_ADDR[7:0];
              HOST_DOUT_VALID <= 1'b1;
            end
            `LCO_CMD_MEM_READ:  st_r <= ST_MRD;
            default:            st_r <= ST_IDLE;
          endcase
          pidx_r <= (cmd_w == `LCO_CMD_CHARGEN);
        end
      end
      else if (DAT_WR)
      begin
        case (st_r)
          ST_FORM:
          begin
            pidx_r <= 1'b1;
            if (!pidx_r)
              CURSOR_HORZ <= HOST_DIN[3:0];
            else
            begin
              CURSOR_VERT_FIELD   <= HOST_DIN[3:0];
              CURSOR_VERT_ILLEGAL <= (HOST_DIN[3:0] == 4'h0);
              CURSOR_SHAPE_BIT    <= HOST_DIN[`LCO_FORM_CM_BIT];
              UNDERLINE_ROW       <= HOST_DIN[3:0];
              BLOCK_HEIGHT        <= {1'b0, HOST_DIN[3:0]} + 5'h01;
            end
          end
          ST_OVL:
          begin
            // one method for the whole layer
            COMPOSITION_SELECT <= HOST_DIN[`LCO_OV_MX_LO+1:`LCO_OV_MX_LO];
            BLOCK1_MODE_BIT    <= HOST_DIN[`LCO_OV_DM1_BIT];
            BLOCK3_MODE_BIT    <= HOST_DIN[`LCO_OV_DM2_BIT];
            BLOCK1_GRAPHICS    <= HOST_DIN[`LCO_OV_DM1_BIT];
            BLOCK3_GRAPHICS    <= HOST_DIN[`LCO_OV_DM2_BIT];
            LAYER_COUNT_BIT    <= HOST_DIN[`LCO_OV_OV_BIT];
            LAYER3_ENABLE      <= HOST_DIN[`LCO_OV_OV_BIT] & HOST_DIN[`LCO_OV_DM1_BIT];
          end
          ST_HSCR:
          begin
            if (!pidx_r)
              PIXEL_HSCROLL <= HOST_DIN[2:0];
            else
              CHARGEN_BASE[7:0] <= HOST_DIN;
            if (pidx_r)
              st_r <= ST_CURSOR_ADDR_READ_CMD;
          end
          ST_CURSOR_ADDR_WRITE_CMD:
          begin
            pidx_r <= 1'b1;
            if (!pidx_r)
              CURSOR_ADDR[7:0] <= HOST_DIN;
            else
              CURSOR_ADDR[AW-1:8] <= HOST_DIN[AW-9:0];
          end
          ST_MWR:
            if (bq_ready)
              CURSOR_ADDR <= CURSOR_ADDR + step_r;
          default:
          begin
            if (st_r == ST_CURSOR_ADDR_READ_CMD && pidx_r)
              CHARGEN_BASE[15:8] <= HOST_DIN;
          end
        endcase
      end
      else if (DAT_RD)
      begin
        if (st_r == ST_CURSOR_ADDR_READ_CMD && !hi_next_r)
        begin
          hi_next_r <= 1'b1;
          HOST_DOUT <= CURSOR_ADDR[AW-1:8];
        end
        else if (st_r == ST_CURSOR_ADDR_READ_CMD)
          HOST_DOUT_VALID <= 1'b0;
        else if (st_r == ST_MRD && HOST_DOUT_VALID)
        begin
          HOST_DOUT_VALID <= 1'b0;
          CURSOR_ADDR     <= CURSOR_ADDR + step_r;
        end
      end
    end
  end
endmodule // lco_cmd

// ===== tb/lco_cmd_monitor.sv
/*
  lco_cmd_monitor.sv: port assertions for the command interpreter.
  assumes: bound to lco_cmd, one clock, sync active-low reset.
*/
`timescale 1ns/100ps
module lco_cmd_monitor
#(
  parameter AW = 16
)
(
  // clock and reset
  input wire          CLK_SYS,
  input wire          RST_N,
  // host side
  input wire          CMD_WR,
  input wire          DAT_WR,
  input wire          DAT_RD,
  input wire [7:0]    HOST_DOUT,
  input wire          HOST_DOUT_VALID,
  input wire          CURSOR_SHOWN,
  // memory side
  input wire          MEM_REQ,
  input wire          MEM_WE,
  input wire [AW-1:0] MEM_ADDR,
  input wire          MEM_READY,
  input wire          MEM_RD_VALID,
  input wire [7:0]    MEM_RDATA,
  // state
  input wire [AW-1:0] CURSOR_ADDR,
  input wire [3:0]    CURSOR_VERT_FIELD,
  input wire          CURSOR_VERT_ILLEGAL,
  input wire [3:0]    UNDERLINE_ROW,
  input wire [4:0]    BLOCK_HEIGHT,
  input wire          BLOCK1_MODE_BIT,
  input wire          LAYER_COUNT_BIT,
  input wire          LAYER3_ENABLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_zero_illegal:
    assert property (CURSOR_VERT_ILLEGAL == (CURSOR_VERT_FIELD == 4'h0)) else $error("flag wrong");
  a_height_map:
    assert property (BLOCK_HEIGHT == CURSOR_VERT_FIELD + 5'h01 && UNDERLINE_ROW == CURSOR_VERT_FIELD)
    else $error("height map wrong");
  a_layer3_gate:
    assert property (LAYER3_ENABLE == (LAYER_COUNT_BIT & BLOCK1_MODE_BIT)) else $error("layer3 wrong");
  a_addr_cause:
    assert property (!$stable(CURSOR_ADDR) |-> $past(DAT_WR) || $past(DAT_RD) || $past(DAT_RD, 2))
    else $error("cursor moved alone");
  a_req_holds:
    assert property (MEM_REQ && !MEM_READY |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
    else $error("request dropped");
  a_fetch_lands:
    assert property (MEM_RD_VALID && !CMD_WR |=> HOST_DOUT_VALID && HOST_DOUT == $past(MEM_RDATA))
    else $error("read data lost");
  a_dout_stands:
    assert property (HOST_DOUT_VALID && !DAT_RD && !CMD_WR |=> HOST_DOUT_VALID && $stable(HOST_DOUT))
    else $error("output buffer moved");
  a_read_ahead:
    assert property (MEM_REQ && !MEM_WE |-> MEM_ADDR == AW'(CURSOR_ADDR + (CURSOR_SHOWN ? 2 : 0)))
    else $error("fetch address wrong");
  cover property (MEM_REQ && MEM_WE && MEM_READY);
  cover property (MEM_RD_VALID);
  cover property (CURSOR_VERT_ILLEGAL);
endmodule // lco_cmd_monitor

bind lco_cmd lco_cmd_monitor #(.AW(AW)) i_lco_cmd_monitor (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CMD_WR(CMD_WR), .DAT_WR(DAT_WR), .DAT_RD(DAT_RD),
  .HOST_DOUT(HOST_DOUT), .HOST_DOUT_VALID(HOST_DOUT_VALID), .CURSOR_SHOWN(CURSOR_SHOWN),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_READY(MEM_READY),
  .MEM_RD_VALID(MEM_RD_VALID), .MEM_RDATA(MEM_RDATA), .CURSOR_ADDR(CURSOR_ADDR),
  .CURSOR_VERT_FIELD(CURSOR_VERT_FIELD), .CURSOR_VERT_ILLEGAL(CURSOR_VERT_ILLEGAL),
  .UNDERLINE_ROW(UNDERLINE_ROW), .BLOCK_HEIGHT(BLOCK_HEIGHT), .BLOCK1_MODE_BIT(BLOCK1_MODE_BIT),
  .LAYER_COUNT_BIT(LAYER_COUNT_BIT), .LAYER3_ENABLE(LAYER3_ENABLE));

// ===== tb/lco_mem_model.sv
/*
  lco_mem_model.sv: display memory behind the interpreter.
  assumes: request held until ready; slow adds wait cycles.
*/
`timescale 1ns/100ps
module lco_mem_model
(
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // request side
  input wire        slow,
  input wire        mem_req,
  input wire        mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0]  mem_wdata,
  // answer side
  output reg        mem_ready = 1'b0,
  output reg        mem_rd_valid = 1'b0,
  output reg [7:0]  mem_rdata = 8'h00
);
  reg     [7:0] mem [0:65535];
  reg     [1:0] wait_r = 2'h0;
  integer       i;
  initial
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5A;
  always @(posedge clk)
  begin
    mem_rd_valid <= 1'b0;
    // no stale data: bus toggles when idle
    mem_rdata <= ~mem_rdata;
    if (!rst_n || (mem_req && mem_ready))
    begin
      mem_ready <= 1'b0;
      wait_r <= 2'h0;
      if (rst_n && mem_we)
        mem[mem_addr] <= mem_wdata;
      mem_rd_valid <= rst_n && !mem_we;
      if (rst_n && !mem_we)
        mem_rdata <= mem[mem_addr];
    end
    else if (mem_req)
    begin
      wait_r <= wait_r + 2'h1;
      mem_ready <= !slow || wait_r == 2'h3;
    end
  end
endmodule // lco_mem_model

// ===== tb/lco_cmd_bench.sv
/*
  lco_cmd_bench.sv: self-checking bench for lco_cmd with memory model.
  assumes: 40 MHz clock, strobes driven by non-blocking assignment.
*/
`timescale 1ns/100ps
`include "lco_defs.vh"
`define CHK(s, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", s, e, a); end end
module lco_cmd_bench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         cmd_wr = 1'b0;
  reg         dat_wr = 1'b0;
  reg         dat_rd = 1'b0;
  reg  [7:0]  din = 8'h00;
  reg  [15:0] pitch = 16'h0050;
  reg         shown = 1'b0;
  reg         slow = 1'b0;
  wire [7:0]  dout, wdata, rdata;
  wire [15:0] maddr, caddr, cgb;
  wire [3:0]  hz, vf, ul;
  wire [4:0]  bh;
  wire [2:0]  hs;
  wire [1:0]  mix;
  wire        dval, req, we, rdy, rval, shp, ill, dh, dl, m1, m3, lc, l3, g1, g3;
  integer     miscompares = 0;
  integer     checked = 0;
  integer     n, k, j;
  reg  [15:0] e;
  lco_cmd #(.AW(16)) i_lco_cmd (.CLK_SYS(clk), .RST_N(rst_n), .CMD_WR(cmd_wr),
    .DAT_WR(dat_wr), .HOST_DIN(din), .DAT_RD(dat_rd), .HOST_DOUT(dout),
    .HOST_DOUT_VALID(dval), .ADDR_PITCH(pitch), .CURSOR_SHOWN(shown), .MEM_REQ(req),
    .MEM_WE(we), .MEM_ADDR(maddr), .MEM_WDATA(wdata), .MEM_READY(rdy), .MEM_RD_VALID(rval),
    .MEM_RDATA(rdata), .CURSOR_ADDR(caddr), .CURSOR_HORZ(hz), .CURSOR_VERT_FIELD(vf),
    .CURSOR_SHAPE_BIT(shp), .CURSOR_VERT_ILLEGAL(ill), .UNDERLINE_ROW(ul), .BLOCK_HEIGHT(bh),
    .DIR_SELECT_HI(dh), .DIR_SELECT_LO(dl), .COMPOSITION_SELECT(mix), .BLOCK1_MODE_BIT(m1),
    .BLOCK3_MODE_BIT(m3), .LAYER_COUNT_BIT(lc), .LAYER3_ENABLE(l3), .BLOCK1_GRAPHICS(g1),
    .BLOCK3_GRAPHICS(g3), .PIXEL_HSCROLL(hs), .CHARGEN_BASE(cgb));
  lco_mem_model i_lco_mem_model (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(req),
    .mem_we(we), .mem_addr(maddr), .mem_wdata(wdata), .mem_ready(rdy), .mem_rd_valid(rval),
    .mem_rdata(rdata));
  always #12.5 clk = ~clk;
  task tick(input integer c);
    repeat (c) @(posedge clk);
  endtask
  // gap cycle between strobes keeps one assignment per edge
  task put(input c, input [7:0] b);
  begin
    @(posedge clk);
    cmd_wr <= c;
    dat_wr <= !c;
    din <= b;
    @(posedge clk);
    cmd_wr <= 1'b0;
    dat_wr <= 1'b0;
    tick(1);
  end
  endtask
  task rd;
  begin
    @(posedge clk);
    dat_rd <= 1'b1;
    @(posedge clk);
    dat_rd <= 1'b0;
    tick(2);
  end
  endtask
  task waitv;
  begin
    for (n = 0; dval !== 1'b1 && n < 100; n = n + 1)
      @(posedge clk);
    `CHK("valid", 1'b1, dval)
  end
  endtask
  task drain;
  begin
    j = 0;
    for (n = 0; j < 4 && n < 200; n = n + 1)
    begin
      @(posedge clk);
      j = req ? 0 : j + 1;
    end
    `CHK("drain", 1'b0, req)
  end
  endtask
  task cursor_addr_write_cmd(input [15:0] a);
  begin
    put(1, `LCO_CMD_CSR_WRITE);
    put(0, a[7:0]);
    put(0, a[15:8]);
    `CHK("cursor_addr_write_cmd", a, caddr)
  end
  endtask
  function [15:0] step(input [15:0] a, input [1:0] d);
    case (d)
      2'h0: step = a + 16'h0001;
      2'h1: step = a - 16'h0001;
      2'h2: step = a - pitch;
      default: step = a + pitch;
    endcase
  endfunction
  task t_form;
    for (k = 0; k < 4; k = k + 1)
    begin
      put(1, `LCO_CMD_CSR_FORM);
      put(0, 8'h0F ^ k[7:0]);
      // blocks still text here, any shape allowed
      put(0, {k[0], 3'h0, 4'h5 * k[3:0]});
      `CHK("vert", 4'h5 * k[3:0], vf)
      `CHK("illegal", k == 0, ill)
      `CHK("height", 5'h01 + 5'h05 * k[4:0], bh)
      `CHK("underline", 4'h5 * k[3:0], ul)
      `CHK("shape", k[0], shp)
      `CHK("horz", 4'hF ^ k[3:0], hz)
    end
  endtask
  task t_ovl;
    for (k = 0; k < 16; k = k + 1)
    begin
      put(1, `LCO_CMD_OVERLAY);
      put(0, {3'h0, k[3], k[2], k[2], k[1:0]});
      `CHK("mix", k[1:0], mix)
      `CHK("modes", {4{k[2]}}, {m3, m1, g3, g1})
      `CHK("layers", k[3], lc)
      `CHK("layer3", k[3] & k[2], l3)
    end
  endtask
  task t_scroll;
  begin
    // line character count set outside this block
    for (k = 0; k < 8; k = k + 1)
    begin
      put(1, `LCO_CMD_HSCROLL);
      put(0, 8'hF8 | k[7:0]);
      `CHK("hscroll", k[2:0], hs)
      `CHK("scroll keeps", 16'h0000, caddr)
    end
    put(1, `LCO_CMD_CHARGEN);
    put(0, 8'h34);
    put(0, 8'h12);
    `CHK("chargen", 16'h1234, cgb)
  end
  endtask
  task t_write;
    for (k = 0; k < 4; k = k + 1)
    begin
      slow <= k[0];
      cursor_addr_write_cmd(16'h1000);
      put(1, 8'h4C | k[7:0]);
      `CHK("dir", k[1:0], {dh, dl})
      put(1, `LCO_CMD_MEM_WRITE);
      put(0, 8'hC0 | k[7:0]);
      put(0, 8'h30 | k[7:0]);
      drain;
      e = step(step(16'h1000, k[1:0]), k[1:0]);
      `CHK("step", e, caddr)
      `CHK("byte0", 8'hC0 | k[7:0], i_lco_mem_model.mem[16'h1000])
      `CHK("byte1", 8'h30 | k[7:0], i_lco_mem_model.mem[step(16'h1000, k[1:0])])
      put(1, `LCO_CMD_CSR_READ);
      waitv;
      `CHK("csr lo", e[7:0], dout)
      rd;
      `CHK("csr hi", e[15:8], dout)
      rd;
      `CHK("csr done", 1'b0, dval)
    end
  endtask
  task t_read;
  begin
    @(posedge clk);
    shown <= 1'b1;
    slow <= 1'b0;
    cursor_addr_write_cmd(16'h2000);
    put(1, 8'h4C);
    put(1, `LCO_CMD_MEM_READ);
    for (k = 0; k < 3; k = k + 1)
    begin
      waitv;
      `CHK("ahead", i_lco_mem_model.mem[16'h2002 + k], dout)
      rd;
      `CHK("rstep", 16'h2001 + k[15:0], caddr)
    end
    waitv;
    shown <= 1'b0;
    slow <= 1'b1;
    cursor_addr_write_cmd(16'h2100);
    put(1, `LCO_CMD_MEM_READ);
    waitv;
    `CHK("plain", i_lco_mem_model.mem[16'h2100], dout)
  end
  endtask
  task results;
  begin
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // watchdog well past the expected run
  initial
  begin
    #400000;
    miscompares++;
    results;
  end
  initial
  begin
    tick(8);
    rst_n <= 1'b1;
    tick(2);
    `CHK("rst", 34'h1_DDD0_0001, {hz, vf, ul, bh, caddr, shp})
    t_form;
    t_ovl;
    t_scroll;
    t_write;
    t_read;
    results;
  end
endmodule // lco_cmd_bench
